// ---- test/rtcr_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtcr_checker #(
   parameter int CAL_PPM_UP   = 4,
   parameter int CAL_PPM_DOWN = 2
) (
   // apb
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // calibration
   input wire logic               lf_tick,
   input wire logic               cal_sign,
   input wire logic [5:0]         cal_magnitude,
   input wire logic signed [9:0]  cal_ppm,
   input wire logic               cal_clock_pin
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       acc;
   logic       wr;
   logic [1:0] sel_q;
   logic       osel_wr;
   assign acc = psel && penable;
   assign wr  = acc && pwrite;
   assign osel_wr = wr && paddr == rtcr_pkg::OFS_CAL_OUTSEL;
   // select shadowed from the bus, so the pin is judged without a read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sel_q <= 2'h0;
      else if (osel_wr)
         sel_q <= pwdata[1:0];
   end
   function automatic logic [31:0] rmask(input logic [7:0] a);
      case (a)
         rtcr_pkg::OFS_CAL_ADJUST: rmask = 32'hBF;
         rtcr_pkg::OFS_CAL_OUTSEL: rmask = 32'h03;
         rtcr_pkg::OFS_SECONDS:    rmask = 32'h7F;
         rtcr_pkg::OFS_MINUTES:    rmask = 32'h7F;
         rtcr_pkg::OFS_HOURS:      rmask = 32'h3F;
         rtcr_pkg::OFS_WEEKDAY:    rmask = 32'h07;
         rtcr_pkg::OFS_FORMAT:     rmask = 32'hFF;
         default:                  rmask = 32'h00;
      endcase
   endfunction
   sequence s_cal_wr;
      wr && paddr == rtcr_pkg::OFS_CAL_ADJUST;
   endsequence
   property p_cal_load;
      s_cal_wr |=> cal_sign == $past(pwdata[7]) &&
         cal_magnitude == $past(pwdata[5:0]);
   endproperty
   property p_cal_hold;
      !(wr && paddr == rtcr_pkg::OFS_CAL_ADJUST) |=>
         $stable(cal_sign) && $stable(cal_magnitude);
   endproperty
   property p_ppm;
      $stable(cal_sign) && $stable(cal_magnitude) |-> cal_ppm == (cal_sign ?
         CAL_PPM_UP * int'(cal_magnitude) : -CAL_PPM_DOWN * int'(cal_magnitude));
   endproperty
   property p_ready;
      acc |-> pready;
   endproperty
   property p_err;
      acc |-> pslverr == (rmask(paddr) == 32'h0);
   endproperty
   property p_unm_rd;
      acc && !pwrite && rmask(paddr) == 32'h0 |-> prdata == 32'h0;
   endproperty
   property p_rd_mask;
      acc && !pwrite |-> (prdata & ~rmask(paddr)) == 32'h0;
   endproperty
   property p_pin_off;
      (sel_q == 2'h0) [*2] |-> !cal_clock_pin;
   endproperty
   // a tap moves three edges after a tick, the mux two after a write
   property p_pin_tick;
      $changed(cal_clock_pin) |-> $past(lf_tick, 3) || $past(osel_wr, 2);
   endproperty
   a_cal_load: assert property (p_cal_load)
      else $error("calibration fields not loaded from write");
   a_cal_hold: assert property (p_cal_hold)
      else $error("calibration fields changed without write");
   a_ppm: assert property (p_ppm)
      else $error("ppm value does not match sign and magnitude");
   a_ready: assert property (p_ready)
      else $error("pready low in access phase");
   a_err: assert property (p_err)
      else $error("pslverr does not match address decode");
   a_unm_rd: assert property (p_unm_rd)
      else $error("unmapped read not zero");
   a_rd_mask: assert property (p_rd_mask)
      else $error("read shows bits outside the field layout");
   a_pin_off: assert property (p_pin_off)
      else $error("calibration pin active while output is off");
   a_pin_tick: assert property (p_pin_tick)
      else $error("calibration pin moved without a tick or select");
endmodule
bind rtcr_top rtcr_checker #(
   .CAL_PPM_UP(CAL_PPM_UP),
   .CAL_PPM_DOWN(CAL_PPM_DOWN)
) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .lf_tick(lf_tick),
   .cal_sign(cal_sign), .cal_magnitude(cal_magnitude),
   .cal_ppm(cal_ppm), .cal_clock_pin(cal_clock_pin)
);
`default_nettype wire

// ---- test/tb_rtcr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_rtcr_top;
   logic               pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic               pwrite = 0, lf_tick = 0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0, prdata, r;
   logic               pready, pslverr, cal_sign, cal_clock_pin, e;
   logic [5:0]         cal_magnitude;
   logic signed [9:0]  cal_ppm;
   int                 bad_count = 0, check_count = 0, seed = 20;
   int                 tv[4];
   logic [7:0]         ofs[4] = '{8'h08, 8'h0C, 8'h10, 8'h14};
   int                 lim[4] = '{60, 60, 24, 7};
   always #10 pclk = ~pclk;
   // tick every second cycle keeps the pin periods short enough to measure
   always @(posedge pclk) lf_tick <= ~lf_tick;
   rtcr_top dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lf_tick(lf_tick),
      .cal_sign(cal_sign), .cal_magnitude(cal_magnitude),
      .cal_ppm(cal_ppm), .cal_clock_pin(cal_clock_pin)
   );
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(0, a, 32'h0);
      chk(r, x);
      chk({31'h0, e}, {31'h0, a > 8'h18});
   endtask
   task automatic meas(input int x);
      int n, t;
      logic p;
      n = 0; t = 0; p = cal_clock_pin;
      while (cal_clock_pin === p && n < 4 * x + 9) begin
         @(posedge pclk); n++;
      end
      n = 0; p = cal_clock_pin;
      while (cal_clock_pin === p && n < 4 * x + 9) begin
         @(posedge pclk); n++; t += lf_tick;
      end
      chk(t, x);
   endtask
   function automatic int bcd(input int v);
      return (v / 10) * 16 + v % 10;
   endfunction
   initial begin
      int v, i, p, k;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      rd(8'h00, 0);
      rd(8'h04, 0);
      rd(8'h18, 0);
      $display("reset test done");
      for (i = 0; i < 6; i++) begin
         v = (i == 0) ? 32'hFF : $random(seed);
         apb(1, 8'h00, v);
         rd(8'h00, v & 32'hBF);
         p = v[7] ? 4 * v[5:0] : -2 * v[5:0];
         chk(32'({cal_sign, cal_magnitude}), 32'({v[7], v[5:0]}));
         chk(32'(cal_ppm), 32'(p));
      end
      $display("calibration test done");
      for (i = 0; i < 4; i++) begin
         apb(1, 8'h04, ($random(seed) & ~3) | i);
         rd(8'h04, i);
         // off and 1 hz must not move where 512 and 256 hz toggle
         k = 0;
         p = cal_clock_pin;
         repeat (300) begin
            @(posedge pclk);
            k += (cal_clock_pin !== p);
            p = cal_clock_pin;
         end
         if (i == 0 || i == 3) chk(k, 0);
         if (i == 0) chk({31'h0, cal_clock_pin}, 32'h0);
         if (i == 1) meas(rtcr_pkg::LF_HZ / 512 / 2);
         if (i == 2) meas(rtcr_pkg::LF_HZ / 256 / 2);
      end
      apb(1, 8'h04, 0);
      $display("output select test done");
      for (p = 0; p < 3; p++) begin
         apb(1, 8'h18, p == 1 ? 32'h80 : 0);
         for (i = 0; i < 4; i++) begin
            tv[i] = p == 0 ? lim[i] - 1 : {$random(seed)} % lim[i];
            v = p == 1 ? bcd(tv[i]) : tv[i];
            apb(1, ofs[i], v | 32'hFFFFFF00);
         end
         apb(1, 8'h18, p == 0 ? 32'h80 : 0);
         for (i = 0; i < 4; i++)
            rd(ofs[i], p == 0 ? bcd(tv[i]) : tv[i]);
      end
      $display("time format test done");
      apb(1, 8'h1C, $random(seed));
      rd(8'h1C, 0);
      rd(8'h04, 0);
      $display("unmapped test done");
      conclude();
   end
endmodule
`default_nettype wire

// ---- verilog/rtcr_cal_out.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtcr_cal_out (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // low-frequency tick, one pulse per 32768 hz period
   input  wire logic                  lf_tick,
   // selection
   input  wire rtcr_pkg::rtcr_calsel_t sel,
   // pin
   output logic                       cal_clock_pin
);

   logic [14:0] cnt_q;
   logic        t512_q;
   logic        t256_q;
   logic        t1_q;

   // one free counter feeds all three taps so they stay phase related
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 15'h0000;
      end else if (lf_tick) begin
         cnt_q <= cnt_q + 15'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t512_q <= 1'b0;
         t256_q <= 1'b0;
         t1_q   <= 1'b0;
      end else begin
         t512_q <= cnt_q[5];
         t256_q <= cnt_q[6];
         t1_q   <= cnt_q[14];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_clock_pin <= 1'b0;
      end else begin
         case (sel) // RULE_04
            rtcr_pkg::CAL_512HZ: cal_clock_pin <= t512_q;
            rtcr_pkg::CAL_256HZ: cal_clock_pin <= t256_q;
            rtcr_pkg::CAL_1HZ:   cal_clock_pin <= t1_q;
            default:             cal_clock_pin <= 1'b0;
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- verilog/rtcr_pkg.sv ----
`default_nettype none

package rtcr_pkg;

   // register byte offsets on the apb slave
   localparam logic [7:0] OFS_CAL_ADJUST  = 8'h00;
   localparam logic [7:0] OFS_CAL_OUTSEL  = 8'h04;
   localparam logic [7:0] OFS_SECONDS     = 8'h08;
   localparam logic [7:0] OFS_MINUTES     = 8'h0C;
   localparam logic [7:0] OFS_HOURS       = 8'h10;
   localparam logic [7:0] OFS_WEEKDAY     = 8'h14;
   localparam logic [7:0] OFS_FORMAT      = 8'h18;

   // field positions
   localparam int CAL_SIGN_BIT      = 7;
   localparam int CAL_MAG_MSB       = 5;
   localparam int FORMAT_DEC_BIT    = 7;

   // reset values
   localparam logic       CAL_SIGN_RST   = 1'b0;
   localparam logic [5:0] CAL_MAG_RST    = 6'h00;
   localparam logic [1:0] CAL_OUTSEL_RST = 2'h0;
   localparam logic       FORMAT_RST     = 1'b0;

   // timing: 32768 hz source divided for the calibration outputs
   localparam int LF_HZ      = 32768;
   localparam int DIV_512    = LF_HZ / 512 / 2;
   localparam int DIV_256    = LF_HZ / 256 / 2;
   localparam int DIV_1      = LF_HZ / 1 / 2;

   typedef enum logic [1:0] {
      CAL_OFF,
      CAL_512HZ,
      CAL_256HZ,
      CAL_1HZ
   } rtcr_calsel_t;

   typedef struct packed {
      logic       sign;
      logic [5:0] magnitude;
   } rtcr_cal_t;

   typedef struct packed {
      logic [5:0] sec;
      logic [5:0] min;
      logic [4:0] hour;
      logic [2:0] dow;
   } rtcr_time_t;

endpackage

`default_nettype wire

// ---- verilog/rtcr_top.sv ----
// Notes on behaviour
// RULE_01: calibration sign bit 7: 0 slows the clock, 1 speeds it up.
// RULE_02: six-bit magnitude in bits 5-0; +4 ppm or -2 ppm per count.
// RULE_03: calibration reserved bits read zero and ignore writes.
// RULE_04: output select 00 off, 01 512 Hz, 10 256 Hz, 11 1 Hz.
// RULE_05: software routes the shared port pin to this function first.
// RULE_06: binary seconds 0 to 59 in bits 5-0, bits 7-6 zero.
// RULE_07: decimal seconds tens in 6-4, units in 3-0, bit 7 zero.
// RULE_08: binary minutes 0 to 59 in bits 5-0, top bits zero.
// RULE_09: decimal minutes tens in 6-4, units in 3-0, bit 7 zero.
// RULE_10: binary hours 0 to 23 in bits 4-0, bits 7-5 zero.
// RULE_11: decimal hours tens in 5-4, units in 3-0, bits 7-6 zero.
// RULE_12: weekday 0 to 6 in bits 2-0, upper bits read zero.
// RULE_13: format bit picks decimal (1) or binary (0) view of time.
// RULE_14: one stored value per unit, both views; no time reset value.
// RULE_15: calibration fields reset to zero: no correction, no output.
`timescale 1ns/1ps
`default_nettype none

module rtcr_top #(
   parameter int CAL_PPM_UP   = 4,
   parameter int CAL_PPM_DOWN = 2
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // low-frequency source tick, one pulse per 32768 hz period
   input  wire logic        lf_tick,
   // calibration state for the counting engine
   output logic             cal_sign,
   output logic [5:0]       cal_magnitude,
   output logic signed [9:0] cal_ppm,
   // calibration output toward the port pin
   output logic             cal_clock_pin
);

   // keeps the full-scale product inside the ten signed bits of cal_ppm
   if (CAL_PPM_UP < 1 || CAL_PPM_UP > 7 || CAL_PPM_DOWN < 1 ||
       CAL_PPM_DOWN > 7) begin
      $error("calibration step out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // apb decode

   logic wr_en;
   logic rd_en;
   logic hit;
   logic sel_cal;
   logic sel_outsel;
   logic sel_sec;
   logic sel_min;
   logic sel_hour;
   logic sel_dow;
   logic sel_fmt;
   logic wr_cal;
   logic wr_outsel;
   logic wr_sec;
   logic wr_min;
   logic wr_hour;
   logic wr_dow;
   logic wr_fmt;

   assign wr_en   = psel && penable && pwrite;
   // reads are looked up in setup so prdata is a register in access
   assign rd_en   = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;

   ////////////////////////////////////////////////////////////////////
   // register strobes

   assign sel_cal    = paddr == rtcr_pkg::OFS_CAL_ADJUST;
   assign sel_outsel = paddr == rtcr_pkg::OFS_CAL_OUTSEL;
   assign sel_sec    = paddr == rtcr_pkg::OFS_SECONDS;
   assign sel_min    = paddr == rtcr_pkg::OFS_MINUTES;
   assign sel_hour   = paddr == rtcr_pkg::OFS_HOURS;
   assign sel_dow    = paddr == rtcr_pkg::OFS_WEEKDAY;
   assign sel_fmt    = paddr == rtcr_pkg::OFS_FORMAT;

   // unmapped writes match no strobe, so they are dropped
   assign wr_cal    = wr_en && sel_cal;
   assign wr_outsel = wr_en && sel_outsel;
   assign wr_sec    = wr_en && sel_sec;
   assign wr_min    = wr_en && sel_min;
   assign wr_hour   = wr_en && sel_hour;
   assign wr_dow    = wr_en && sel_dow;
   assign wr_fmt    = wr_en && sel_fmt;

   always_comb begin
      if (paddr == rtcr_pkg::OFS_CAL_ADJUST) begin
         hit = 1'b1;
      end else if (paddr == rtcr_pkg::OFS_CAL_OUTSEL) begin
         hit = 1'b1;
      end else if (paddr == rtcr_pkg::OFS_SECONDS) begin
         hit = 1'b1;
      end else if (paddr == rtcr_pkg::OFS_MINUTES) begin
         hit = 1'b1;
      end else if (paddr == rtcr_pkg::OFS_HOURS) begin
         hit = 1'b1;
      end else if (paddr == rtcr_pkg::OFS_WEEKDAY) begin
         hit = 1'b1;
      end else if (paddr == rtcr_pkg::OFS_FORMAT) begin
         hit = 1'b1;
      end else begin
         hit = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // format conversion

   // binary value to two decimal digits, tens in [6:4]
   function automatic logic [7:0] to_dec(input logic [5:0] v);
      logic [3:0] tens;
      logic [5:0] rem;
      tens = 4'h0;
      rem  = v;
      for (int i = 0; i < 6; i++) begin
         if (rem >= 6'd10) begin
            rem  = rem - 6'd10;
            tens = tens + 4'h1;
         end
      end
      return {1'b0, tens[2:0], rem[3:0]};
   endfunction

   // two decimal digits back to binary; tens * 10 = tens*8 + tens*2
   function automatic logic [5:0] from_dec(input logic [2:0] tens,
                                           input logic [3:0] units);
      logic [6:0] sum;
      sum = {1'b0, tens, 3'b000} + {3'b000, tens, 1'b0} + {3'b000, units};
      return sum[5:0];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // control registers

   rtcr_pkg::rtcr_cal_t    cal_q;
   rtcr_pkg::rtcr_calsel_t outsel_q;
   logic                   dec_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_q.sign      <= rtcr_pkg::CAL_SIGN_RST; // RULE_15
         cal_q.magnitude <= rtcr_pkg::CAL_MAG_RST;
      end else if (wr_cal) begin
         cal_q.sign      <= pwdata[rtcr_pkg::CAL_SIGN_BIT]; // RULE_01
         cal_q.magnitude <= pwdata[rtcr_pkg::CAL_MAG_MSB:0]; // RULE_02
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         outsel_q <= rtcr_pkg::rtcr_calsel_t'(rtcr_pkg::CAL_OUTSEL_RST);
      end else if (wr_outsel) begin
         outsel_q <= rtcr_pkg::rtcr_calsel_t'(pwdata[1:0]); // RULE_03
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_q <= rtcr_pkg::FORMAT_RST;
      end else if (wr_fmt) begin
         dec_q <= pwdata[rtcr_pkg::FORMAT_DEC_BIT]; // RULE_13
      end
   end

   ////////////////////////////////////////////////////////////////////
   // time registers: stored binary, no reset so power-up is undefined

   rtcr_pkg::rtcr_time_t tm_q;
   logic [5:0]           sec_d;
   logic [5:0]           min_d;
   logic [4:0]           hour_d;
   logic [2:0]           dow_d;

   // written digits go to binary here, so both views share one store
   always_comb begin
      if (dec_q) begin
         sec_d  = from_dec(pwdata[6:4], pwdata[3:0]); // RULE_07
         min_d  = from_dec(pwdata[6:4], pwdata[3:0]); // RULE_09
         hour_d = 5'(from_dec({1'b0, pwdata[5:4]}, pwdata[3:0])); // RULE_11
      end else begin
         sec_d  = pwdata[5:0]; // RULE_06
         min_d  = pwdata[5:0]; // RULE_08
         hour_d = pwdata[4:0]; // RULE_10
      end
      dow_d = pwdata[2:0]; // RULE_12
   end

   // RULE_14
   always_ff @(posedge pclk) begin
      if (wr_sec) begin
         tm_q.sec <= sec_d;
      end
      if (wr_min) begin
         tm_q.min <= min_d;
      end
      if (wr_hour) begin
         tm_q.hour <= hour_d;
      end
      if (wr_dow) begin
         tm_q.dow <= dow_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read mux, registered so prdata comes from flip-flops

   logic [7:0] rd_d;
   logic [7:0] hr_dec;

   assign hr_dec = to_dec({1'b0, tm_q.hour});

   logic [7:0] sec_rd;
   logic [7:0] min_rd;
   logic [7:0] hour_rd;

   // read views of the stored binary values; values beyond range still convert to exact digits
   always_comb begin
      if (dec_q) begin
         sec_rd  = to_dec(tm_q.sec); // RULE_07
         min_rd  = to_dec(tm_q.min); // RULE_09
         hour_rd = {2'b00, hr_dec[5:0]}; // RULE_11
      end else begin
         sec_rd  = {2'b00, tm_q.sec}; // RULE_06
         min_rd  = {2'b00, tm_q.min}; // RULE_08
         hour_rd = {3'b000, tm_q.hour}; // RULE_10
      end
   end

   always_comb begin
      if (paddr == rtcr_pkg::OFS_CAL_ADJUST) begin
         rd_d = {cal_q.sign, 1'b0, cal_q.magnitude}; // RULE_03
      end else if (paddr == rtcr_pkg::OFS_CAL_OUTSEL) begin
         rd_d = {6'h00, outsel_q}; // RULE_03
      end else if (paddr == rtcr_pkg::OFS_SECONDS) begin
         rd_d = sec_rd;
      end else if (paddr == rtcr_pkg::OFS_MINUTES) begin
         rd_d = min_rd;
      end else if (paddr == rtcr_pkg::OFS_HOURS) begin
         rd_d = hour_rd;
      end else if (paddr == rtcr_pkg::OFS_WEEKDAY) begin
         rd_d = {5'h00, tm_q.dow}; // RULE_12
      end else if (paddr == rtcr_pkg::OFS_FORMAT) begin
         rd_d = {dec_q, 7'h00};
      end else begin
         rd_d = 8'h00;
      end
   end

   // read data is captured in the setup cycle so it is stable in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= {24'h00_0000, rd_d};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // calibration to the engine and the pin

   logic signed [9:0] ppm_d;

   // signed correction in ppm; engine applies it to its prescaler
   always_comb begin
      if (cal_q.sign) begin
         ppm_d = 10'(cal_q.magnitude * CAL_PPM_UP); // RULE_02
      end else begin
         ppm_d = -10'(cal_q.magnitude * CAL_PPM_DOWN); // RULE_01
      end
   end

   // registered so the engine never sees a half-written setting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_ppm <= 10'sd0;
      end else begin
         cal_ppm <= ppm_d;
      end
   end

   assign cal_sign      = cal_q.sign;
   assign cal_magnitude = cal_q.magnitude;

   // the pin mux only sources the signal; port routing is software's job
   rtcr_cal_out u_cal_out (
      .pclk          (pclk),
      .presetn       (presetn),
      .lf_tick       (lf_tick),
      .sel           (outsel_q),
      .cal_clock_pin (cal_clock_pin)
   );

endmodule

`default_nettype wire
